// File: hdl/pcie_devcap_pkg.sv
// Constants shared by the capability/control register ends and the link
package pcie_devcap_pkg;
  // Configuration offsets on the link
  localparam logic [7:0] CAP_OFF = 8'hE4;
  localparam logic [7:0] CTL_OFF = 8'hE8;
  // Capabilities word field values
  localparam logic [2:0] MPS_SUPPORTED = 3'h0;
  localparam logic [1:0] PHANTOM_VAL = 2'h0;
  localparam logic [2:0] L0S_LAT_RST = 3'h0;
  localparam logic [2:0] L1_LAT_RST = 3'h0;
  localparam logic RBE_RST = 1'b1;
  localparam logic [7:0] SPL_VAL_RST = 8'h00;
  localparam logic [1:0] SPL_SCALE_RST = 2'h0;
  // Control word field positions
  localparam int CTL_ERR_LSB = 0;
  localparam int CTL_MPS_LSB = 5;
  localparam int CTL_AUX_BIT = 10;
  localparam int STS_LSB = 16;
  // Error class indices
  localparam int ERR_COR = 0;
  localparam int ERR_NF = 1;
  localparam int ERR_FAT = 2;
  localparam int ERR_UR = 3;
  localparam int ERR_N = 4;
  // Controller APB register offsets
  localparam logic [11:0] HOST_CMD = 12'h000;
  localparam logic [11:0] HOST_WDATA = 12'h004;
  localparam logic [11:0] HOST_RDATA = 12'h008;
  localparam logic [11:0] HOST_STATUS = 12'h00C;
  // Controller field positions
  localparam int CMD_BE_LSB = 8;
  localparam int CMD_WE_BIT = 16;
  localparam int CMD_GO_BIT = 31;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
endpackage

// File: hdl/cfg_link_if.sv
// Configuration access link between the controller and the device registers
`timescale 1ns/100ps
interface cfg_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic ack;
  logic [31:0] rdata;
  modport dev (input req, input we, input addr, input wdata, input be,
    output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, output be,
    input ack, input rdata);
endinterface

// File: hdl/pcie_devcap_regs.sv
// Device end: capabilities word and control/status word
`timescale 1ns/100ps
module pcie_devcap_regs
(
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic aux_por_n,
  // Link to configuration software
  cfg_link_if.dev link,
  // Slot power limit message
  input wire logic spl_msg_valid,
  input wire logic [7:0] spl_msg_value,
  input wire logic [1:0] spl_msg_scale,
  // Configuration autoload
  input wire logic autoload_valid,
  input wire logic autoload_rbe,
  // Error events and their reports
  input wire logic [pcie_devcap_pkg::ERR_N-1:0] err_det,
  output logic [pcie_devcap_pkg::ERR_N-1:0] err_msg,
  // Control outputs
  output logic [2:0] max_payload,
  output logic aux_pwr_en
);
  import pcie_devcap_pkg::*;

  typedef struct packed {
    logic [ERR_N-1:0] err_en;
    logic [2:0] mps;
    logic aux_en;
    logic rbe;
    logic [7:0] spl_val;
    logic [1:0] spl_scale;
    logic [ERR_N-1:0] sts;
    logic [ERR_N-1:0] msg;
    logic ack;
    logic [31:0] rdata;
  } state_s;

  localparam state_s ST_RST = '{
    err_en: '0, mps: 3'h0, aux_en: 1'b0, rbe: RBE_RST,
    spl_val: SPL_VAL_RST, spl_scale: SPL_SCALE_RST,
    sts: '0, msg: '0, ack: 1'b0, rdata: 32'h0};

  state_s st;
  state_s next_st;
  logic [31:0] cap_word;
  logic [15:0] ctl_word;

  function automatic logic [2:0] clamp_mps(input logic [2:0] v);
    clamp_mps = (v > MPS_SUPPORTED) ? MPS_SUPPORTED : v;
  endfunction

  assign cap_word = {4'h0, st.spl_scale, st.spl_val, 2'h0, st.rbe, 3'h0,
    L1_LAT_RST, L0S_LAT_RST, 1'b0, PHANTOM_VAL, MPS_SUPPORTED};
  assign ctl_word = {5'h00, st.aux_en, 2'h0, st.mps, 1'b0, st.err_en};

  always_comb
  begin
    next_st = st;
    next_st.ack = 1'b0;
    // Reports gated by enables, one cycle per event
    next_st.msg = err_det & st.err_en;
    next_st.sts = st.sts | err_det;
    if (spl_msg_valid)
    begin
      next_st.spl_val = spl_msg_value;
      next_st.spl_scale = spl_msg_scale;
    end
    if (autoload_valid)
    begin
      next_st.rbe = autoload_rbe;
    end
    if (link.req && !st.ack)
    begin
      next_st.ack = 1'b1;
      case (link.addr)
        CAP_OFF: next_st.rdata = cap_word;
        CTL_OFF: next_st.rdata = {12'h000, st.sts, ctl_word};
        default: next_st.rdata = 32'h0;
      endcase
      if (link.we && link.addr == CTL_OFF)
      begin
        if (link.be[0])
        begin
          next_st.err_en = link.wdata[CTL_ERR_LSB +: ERR_N];
          next_st.mps = clamp_mps(link.wdata[CTL_MPS_LSB +: 3]);
        end
        if (link.be[1])
        begin
          next_st.aux_en = link.wdata[CTL_AUX_BIT];
        end
        if (link.be[2])
        begin
          // Write one clears; a new event wins
          next_st.sts = (st.sts & ~link.wdata[STS_LSB +: ERR_N]) | err_det;
        end
      end
    end
    if (!rst_n)
    begin
      next_st = ST_RST;
      next_st.aux_en = st.aux_en;
    end
    if (!aux_por_n)
    begin
      next_st.aux_en = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    st <= next_st;
  end

  assign link.ack = st.ack;
  assign link.rdata = st.rdata;
  assign err_msg = st.msg;
  assign max_payload = st.mps;
  assign aux_pwr_en = st.aux_en;
endmodule // pcie_devcap_regs

// File: hdl/pcie_cfg_host.sv
// Controller end: APB-commanded configuration accesses over the link
`timescale 1ns/100ps
module pcie_cfg_host
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to device
  cfg_link_if.host link
);
  import pcie_devcap_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] be;
    logic we;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic req;
    logic done;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;

  localparam state_s ST_RST = '{
    addr: 8'h00, be: 4'h0, we: 1'b0, wdata: 32'h0, rdata: 32'h0,
    req: 1'b0, done: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0};

  state_s st;
  state_s next_st;
  logic link_done;

  assign link_done = st.req && link.ack;

  always_comb
  begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // Request held until the device acknowledges
    if (link_done)
    begin
      next_st.req = 1'b0;
      next_st.done = 1'b1;
      if (!st.we)
      begin
        next_st.rdata = link.rdata;
      end
    end
    // Registered answer: one wait state per access
    if (psel && penable && !st.pready)
    begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0;
      case (paddr)
        HOST_CMD:
        begin
          next_st.prdata = {15'h0, st.we, 4'h0, st.be, st.addr};
          // Commands while busy are dropped
          if (pwrite && !st.req)
          begin
            next_st.addr = pwdata[7:0];
            next_st.be = pwdata[CMD_BE_LSB +: 4];
            next_st.we = pwdata[CMD_WE_BIT];
            next_st.req = pwdata[CMD_GO_BIT];
          end
        end
        HOST_WDATA:
        begin
          next_st.prdata = st.wdata;
          if (pwrite && !st.req)
          begin
            next_st.wdata = pwdata;
          end
        end
        HOST_RDATA: next_st.prdata = st.rdata;
        HOST_STATUS:
        begin
          next_st.prdata = {30'h0, st.done, st.req};
          // Completion in the same cycle wins over the clear
          if (pwrite && pwdata[STAT_DONE_BIT])
          begin
            next_st.done = link_done;
          end
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end
    if (!rst_n)
    begin
      next_st = ST_RST;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    st <= next_st;
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign link.req = st.req;
  assign link.we = st.we;
  assign link.addr = st.addr;
  assign link.wdata = st.wdata;
  assign link.be = st.be;
endmodule // pcie_cfg_host

// File: verif/pcie_devcap_sva.sv
// Link checker for the capability/control register ends
`timescale 1ns/100ps
module pcie_devcap_sva
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  import pcie_devcap_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] en_q;
  wire rd_cap = ack && !we && addr == CAP_OFF;
  wire rd_ctl = ack && !we && addr == CTL_OFF;
  // Shadow of the last enables written
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      en_q <= 4'h0;
    else if (ack && we && addr == CTL_OFF && be[0])
      en_q <= wdata[3:0];
  end
  ack_latency_a: assert property ($rose(req) |-> !ack ##1 ack)
    else $error("link ack late");
  ack_pulse_a: assert property (ack |=> !ack [*2])
    else $error("link ack held");
  pay_sup_a: assert property (rd_cap |-> rdata[2:0] == MPS_SUPPORTED)
    else $error("supported payload wrong");
  cap_zero_a: assert property (rd_cap |-> rdata[5:3] == 3'h0 &&
    rdata[14:12] == 3'h0) else $error("unimplemented cap bit set");
  cap_resv_a: assert property (rd_cap |-> rdata[17:16] == 2'h0 &&
    rdata[31:28] == 4'h0) else $error("reserved cap bit set");
  mps_clamp_a: assert property (rd_ctl |-> rdata[7:5] == 3'h0)
    else $error("payload not clamped");
  ctl_zero_a: assert property (rd_ctl |-> rdata[4] == 1'b0 &&
    rdata[9:8] == 2'h0 && rdata[15:11] == 5'h0)
    else $error("fixed control bit set");
  err_en_a: assert property (rd_ctl |-> rdata[3:0] == en_q)
    else $error("enables lost");
  cover property (rd_cap);
  cover property (rd_ctl && rdata[10]);
  cover property (ack && we && addr == CTL_OFF);
endmodule // pcie_devcap_sva

// File: verif/pcie_device_cap_ctrl_regs_tb.sv
// Bench for the capability/control registers and their controller
`timescale 1ns/100ps
module pcie_device_cap_ctrl_regs_tb;
  import pcie_devcap_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, aux_por_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, qe;
  logic spl_msg_valid = 1'b0, autoload_valid = 1'b0, autoload_rbe = 1'b0;
  logic [7:0] spl_msg_value = '0;
  logic [1:0] spl_msg_scale = '0;
  logic [3:0] err_det = '0, err_msg;
  logic [2:0] max_payload;
  logic aux_pwr_en;
  int bad_count = 0, tests_run = 0;
  cfg_link_if link();
  pcie_devcap_regs u_pcie_devcap_regs (.ref_clk, .rst_n, .aux_por_n,
    .link, .spl_msg_valid, .spl_msg_value, .spl_msg_scale, .autoload_valid,
    .autoload_rbe, .err_det, .err_msg, .max_payload, .aux_pwr_en);
  pcie_cfg_host u_pcie_cfg_host (.ref_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link);
  pcie_devcap_sva u_sva (.ref_clk, .rst_n, .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .be(link.be), .ack(link.ack),
    .rdata(link.rdata));
  initial forever #25 ref_clk = ~ref_clk;
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  // Judged on the awaited answer, not the loop count
  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      bad_count++;
      conclude;
    end
  endtask
  // Request held until pready seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    tmo(pready === 1'b1);
    q = prdata;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic w, input logic [7:0] a,
    input logic [3:0] b, input logic [31:0] d);
    int n;
    n = 0;
    apb(1'b1, HOST_WDATA, d);
    apb(1'b1, HOST_CMD, {1'b1, 14'h0, w, 4'h0, b, a});
    q = '0;
    while (q[STAT_DONE_BIT] !== 1'b1 && n < 50)
    begin
      apb(1'b0, HOST_STATUS, '0);
      n++;
    end
    tmo(q[STAT_DONE_BIT] === 1'b1);
    apb(1'b1, HOST_STATUS, 32'h0000_0002);
    apb(1'b0, HOST_RDATA, '0);
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    aux_por_n <= 1'b1;
    cfg(1'b0, CAP_OFF, 4'h0, '0);
    chk("cap", 32'h0000_8000, q);
    chk("pslverr", 32'h0, {31'h0, qe}); // host map
    cfg(1'b0, CTL_OFF, 4'h0, '0);
    chk("ctl", 32'h0, q);
    $display("test reset end");
    cfg(1'b1, CTL_OFF, 4'h3, 32'hFFFF_FFFF);
    cfg(1'b0, CTL_OFF, 4'h0, '0);
    chk("ctl", 32'h0000_040F, q);
    chk("mps", 32'h0, {29'h0, max_payload});
    chk("aux_pwr_en", 32'h1, {31'h0, aux_pwr_en});
    $display("test control end");
    apb(1'b0, HOST_CMD, '0);
    chk("host_cmd", 32'h0000_00E8, q); // host map
    apb(1'b0, 12'h010, '0);
    chk("pslverr", 32'h1, {31'h0, qe}); // host map
    chk("unmapped", 32'h0, q); // host map
    $display("test host map end");
    spl_msg_value <= 8'hA5;
    spl_msg_scale <= 2'h2;
    spl_msg_valid <= 1'b1;
    autoload_valid <= 1'b1;
    @(posedge ref_clk);
    spl_msg_valid <= 1'b0;
    autoload_valid <= 1'b0;
    cfg(1'b1, CAP_OFF, 4'hF, 32'hFFFF_FFFF);
    cfg(1'b0, CAP_OFF, 4'h0, '0);
    chk("cap", 32'h0A94_0000, q);
    $display("test capture end");
    cfg(1'b1, CTL_OFF, 4'h1, 32'h0000_0005);
    err_det <= 4'hF;
    @(posedge ref_clk);
    err_det <= 4'h0;
    #1 chk("err_msg", 32'h5, {28'h0, err_msg});
    cfg(1'b0, CTL_OFF, 4'h0, '0);
    chk("sts", 32'h000F_0405, q);
    cfg(1'b1, CTL_OFF, 4'h4, 32'h000F_0000);
    cfg(1'b0, CTL_OFF, 4'h0, '0);
    chk("sts", 32'h0000_0405, q);
    $display("test errors end");
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    cfg(1'b0, CTL_OFF, 4'h0, '0);
    chk("ctl", 32'h0000_0400, q);
    cfg(1'b0, CAP_OFF, 4'h0, '0);
    chk("cap", 32'h0000_8000, q);
    aux_por_n <= 1'b0;
    @(posedge ref_clk);
    aux_por_n <= 1'b1;
    #1 chk("aux", 32'h0, {31'h0, aux_pwr_en});
    $display("test sticky end");
    conclude;
  end
endmodule // pcie_device_cap_ctrl_regs_tb
